//--- mat_buffer_model.sv
// module buffer model: answers sync packets with a temperature status
`timescale 1ns/1ps
`default_nettype none
module mat_buffer_model (
    input wire logic sys_clk_i,
    input wire logic [3:0] sync_i,
    input wire logic [3:0] zone_i,
    input wire logic [1:0] slow_i,
    output logic [1:0] status_valid_o = 2'h0,
    output logic [1:0] temp_above_low_o = 2'h0,
    output logic [1:0] temp_above_mid_o = 2'h0
);
    int wq[2] = '{0, 0};
    ////////////////////////////////////////////////////////////
    // answer after 2 or 9 cycles; temp lines toggle when not valid so stale bits never look good
    always @(negedge sys_clk_i) begin
        for (int b = 0; b < 2; b++) begin
            status_valid_o[b] <= 1'b0;
            temp_above_low_o[b] <= ~temp_above_low_o[b];
            temp_above_mid_o[b] <= ~temp_above_mid_o[b];
            if (sync_i[2*b]) begin
                wq[b] = slow_i[b] ? 9 : 2;
            end else if (wq[b] > 0) begin
                wq[b]--;
                if (wq[b] == 0) begin
                    status_valid_o[b] <= 1'b1;
                    temp_above_low_o[b] <= zone_i[2*b+:2] != 2'h0;
                    temp_above_mid_o[b] <= zone_i[2*b+:2] == 2'h2;
                end
            end
        end
    end
endmodule : mat_buffer_model
`default_nettype wire

//--- mat_pkg.sv
// shared constants and types for the memory activate throttler
package mat_pkg;

    // thermal window and global window lengths
    localparam int TW_CYCLES = 1344;
    localparam int TW_W = 11;
    localparam int GW_NORMAL_TW = 16384;
    localparam int GW_SHORT_TW = 4;
    localparam int GW_W = 15;
    // quiet global windows needed before the global flag drops
    localparam int QUIET_NORMAL = 16;
    localparam int QUIET_SHORT = 2;
    localparam int QC_W = 5;
    // closed-loop look-back depth in global windows
    localparam int HIST_DEPTH = 8;
    // global limit granularity: one unit is 2**shift activates
    localparam int UNIT_SHIFT_SHORT = 4;
    localparam int UNIT_SHIFT_NORMAL = 16;
    localparam int GLIM_W = 8;
    localparam int GC_W = 25;
    // sync packet cadence in frames
    localparam int SYNC_FRAMES = 42;
    localparam int SYNC_W = 6;
    // electrical throttle: activates per rank per sliding window
    localparam int FAW_MAX_ACTS = 4;
    localparam int FAW_TIME_PS = 37500;
    localparam int CLK_PERIOD_PS = 20000;
    localparam int FAW_MIN_CYC = (FAW_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RANKS_PER_PAIR = 2;
    // grace accesses after a stall begins: follow-on plus one page hit
    localparam logic [1:0] GRACE_ACCESSES = 2'h2;

    typedef enum logic [1:0] {
        MAT_LVL_LOW = 2'b00,
        MAT_LVL_MID = 2'b01,
        MAT_LVL_HIGH = 2'b10
    } mat_level_t;

endpackage : mat_pkg

//--- mat_rank_faw.sv
// sliding-window activate limiter for one rank
`timescale 1ns/1ps
`default_nettype none
module mat_rank_faw
    import mat_pkg::*;
#(
    parameter int EW = 5
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic en_i,
    input wire logic act_i,
    input wire logic [EW-1:0] win_i,
    output logic block_o
);

    typedef struct packed {
        logic [FAW_MAX_ACTS-1:0][EW-1:0] tmr;
        logic block;
    } mat_faw_st_t;

    mat_faw_st_t st_ff;
    mat_faw_st_t nxt_st;
    logic [FAW_MAX_ACTS-1:0] busy;
    logic expiring;

    ////////////////////////////////////////////////////////////////////////
    // one timer per remembered activate; a window below the floor is raised
    always_comb begin
        logic [EW-1:0] win;
        logic placed;
        win = (win_i < EW'(FAW_MIN_CYC)) ? EW'(FAW_MIN_CYC) : win_i;
        placed = 1'b0;
        nxt_st = st_ff;
        expiring = 1'b0;
        for (int i = 0; i < FAW_MAX_ACTS; i++) begin
            busy[i] = st_ff.tmr[i] != '0;
            if (st_ff.tmr[i] == EW'(1)) begin
                expiring = 1'b1;
            end
        end
        if (ce_i) begin
            for (int i = 0; i < FAW_MAX_ACTS; i++) begin
                if (busy[i]) begin
                    nxt_st.tmr[i] = st_ff.tmr[i] - 1'b1;
                end else if (act_i && en_i && !placed) begin
                    nxt_st.tmr[i] = win - 1'b1;
                    placed = 1'b1;
                end
            end
            nxt_st.block = en_i;
            for (int i = 0; i < FAW_MAX_ACTS; i++) begin
                if (nxt_st.tmr[i] == '0) begin
                    nxt_st.block = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign block_o = st_ff.block;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_faw_expire_free: assert property (ce_i && en_i && expiring && !act_i |=> !block_o)
        else $error("rank still blocked after oldest activate left window");
    chk_faw_block_full: assert property (ce_i && en_i && act_i && $countones(busy) == FAW_MAX_ACTS - 1
        && !(|(st_ff.tmr & {FAW_MAX_ACTS{EW'(1)}})) |=> block_o)
        else $error("fourth activate in window did not block rank");
    chk_faw_disabled: assert property (ce_i && !en_i |=> !block_o)
        else $error("rank blocked with electrical throttle disabled");

endmodule : mat_rank_faw
`default_nettype wire

//--- mat_sync_gen.sv
// one sync packet request every fixed number of frames on a channel
`timescale 1ns/1ps
`default_nettype none
module mat_sync_gen
    import mat_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic frame_tick_i,
    output logic sync_send_o
);

    typedef struct packed {
        logic [SYNC_W-1:0] cnt;
        logic sync;
    } mat_sync_st_t;

    mat_sync_st_t st_ff;
    mat_sync_st_t nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // frame counter, pulse on the last frame of each group
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync = 1'b0;
        if (ce_i && frame_tick_i) begin
            if (st_ff.cnt == SYNC_W'(SYNC_FRAMES - 1)) begin
                nxt_st.cnt = '0;
                nxt_st.sync = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end else if (!ce_i) begin
            nxt_st.sync = st_ff.sync;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_send_o = st_ff.sync;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    chk_sync_cadence: assert property (ce_i && frame_tick_i && st_ff.cnt == SYNC_W'(SYNC_FRAMES - 1)
        |=> sync_send_o && st_ff.cnt == '0)
        else $error("sync packet not requested at end of frame group");

endmodule : mat_sync_gen
`default_nettype wire

//--- mat_throttle_top.sv
// per-branch activate throttling: thermal, global and electrical limits
`timescale 1ns/1ps
`default_nettype none
module mat_throttle_top
    import mat_pkg::*;
#(
    parameter int NB = 2,
    parameter int NP = 8,
    parameter int LW = 16,
    parameter int EW = 5,
    parameter int NCH = 4,
    parameter int GW_TW = GW_NORMAL_TW
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic closed_loop_select_i,
    input wire logic short_window_select_i,
    input wire logic [GLIM_W-1:0] global_activate_limit_i,
    input wire logic [LW-1:0] low_throttle_level_i,
    input wire logic [LW-1:0] mid_throttle_level_i,
    input wire logic [LW-1:0] high_throttle_level_i,
    input wire logic [NB*NP-1:0] per_pair_electrical_enable_i,
    input wire logic [EW-1:0] electrical_window_setting_i,
    input wire logic [NB-1:0] act_valid_i,
    input wire logic [NB*$clog2(NP)-1:0] act_pair_i,
    input wire logic [NB-1:0] act_rank_i,
    input wire logic [NB-1:0] page_open_i,
    input wire logic [NB-1:0] cas_issue_i,
    input wire logic [NB-1:0] status_valid_i,
    input wire logic [NB-1:0] temp_above_low_i,
    input wire logic [NB-1:0] temp_above_mid_i,
    input wire logic [NCH-1:0] frame_tick_i,
    output logic [NB-1:0] global_throttle_flag_o,
    output logic [NB*LW-1:0] active_throttle_limit_o,
    output logic [NB*2-1:0] throttle_level_o,
    output logic [NB-1:0] branch_stall_o,
    output logic [NB-1:0] cas_allow_o,
    output logic [NB*NP*RANKS_PER_PAIR-1:0] rank_act_block_o,
    output logic [NCH-1:0] sync_send_o
);

    localparam int PW = $clog2(NP);

    typedef struct packed {
        logic [TW_W-1:0] tw_cnt;
        logic [GW_W-1:0] gw_cnt;
        logic [NB-1:0][NP-1:0][GC_W-1:0] gcnt;
        logic [NB-1:0][NP-1:0][LW-1:0] tcnt;
        logic [NB-1:0][HIST_DEPTH-1:0] hist;
        logic [NB-1:0][QC_W-1:0] quiet;
        logic [NB-1:0] gflag;
        logic [NB-1:0][1:0] zone;
        logic [NB-1:0][1:0] level;
        logic [NB-1:0][LW-1:0] limit;
        logic [NB-1:0] stall;
        logic [NB-1:0][1:0] grace;
        logic [NB-1:0] cas_ok;
    } mat_st_t;

    mat_st_t st_ff;
    mat_st_t nxt_st;
    logic tw_end;
    logic gw_end;
    logic [GW_W-1:0] gw_last;
    logic [QC_W-1:0] quiet_last;
    logic [GC_W-1:0] glim_scaled;
    logic [NB-1:0] exceeded;

    ////////////////////////////////////////////////////////////////////////
    // level choice from loop mode, temperature zone and global flag
    function automatic mat_level_t pick_level(input logic closed, input logic [1:0] zone, input logic flag);
        mat_level_t lvl;
        lvl = flag ? MAT_LVL_MID : MAT_LVL_LOW;
        if (closed) begin
            if (zone == MAT_LVL_HIGH) begin
                lvl = MAT_LVL_HIGH;
            end else if (zone == MAT_LVL_MID) begin
                lvl = MAT_LVL_MID;
            end
        end
        // open loop never looks at the zone, so temperature cannot raise it
        return lvl;
    endfunction : pick_level

    function automatic logic [LW-1:0] level_limit(input logic [1:0] lvl, input logic [LW-1:0] lo,
                                                   input logic [LW-1:0] mid, input logic [LW-1:0] hi);
        logic [LW-1:0] val;
        unique case (lvl)
            MAT_LVL_LOW: val = lo;
            MAT_LVL_MID: val = mid;
            MAT_LVL_HIGH: val = hi;
            default: val = mid;
        endcase
        return val;
    endfunction : level_limit

    ////////////////////////////////////////////////////////////////////////
    // window boundaries; the short select is for validation runs
    assign tw_end = st_ff.tw_cnt == TW_W'(TW_CYCLES - 1);
    assign gw_last = short_window_select_i ? GW_W'(GW_SHORT_TW - 1) : GW_W'(GW_TW - 1);
    assign gw_end = tw_end && st_ff.gw_cnt == gw_last;
    assign quiet_last = short_window_select_i ? QC_W'(QUIET_SHORT - 1) : QC_W'(QUIET_NORMAL - 1);
    // one limit unit is 16 activates in short mode, 65536 otherwise
    assign glim_scaled = short_window_select_i ? GC_W'({global_activate_limit_i, 4'h0})
                                               : GC_W'({global_activate_limit_i, 16'h0000});

    // any pair of a branch strictly above the global limit
    always_comb begin
        for (int b = 0; b < NB; b++) begin
            exceeded[b] = 1'b0;
            for (int p = 0; p < NP; p++) begin
                if (st_ff.gcnt[b][p] > glim_scaled) begin
                    exceeded[b] = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic for all branches
    always_comb begin
        logic hit;
        logic act;
        logic [HIST_DEPTH-1:0] nhist;
        hit = 1'b0;
        act = 1'b0;
        nhist = '0;
        nxt_st = st_ff;
        if (ce_i) begin
            nxt_st.tw_cnt = tw_end ? '0 : st_ff.tw_cnt + 1'b1;
            if (tw_end) begin
                nxt_st.gw_cnt = gw_end ? '0 : st_ff.gw_cnt + 1'b1;
            end
            for (int b = 0; b < NB; b++) begin
                // per-pair activate counting; an activate on a boundary opens the new window
                for (int p = 0; p < NP; p++) begin
                    act = act_valid_i[b] && act_pair_i[b*PW +: PW] == PW'(p);
                    if (gw_end) begin
                        nxt_st.gcnt[b][p] = GC_W'(act);
                    end else if (act && !(&st_ff.gcnt[b][p])) begin
                        nxt_st.gcnt[b][p] = st_ff.gcnt[b][p] + 1'b1;
                    end
                    if (tw_end) begin
                        nxt_st.tcnt[b][p] = LW'(act);
                    end else if (act && !(&st_ff.tcnt[b][p])) begin
                        nxt_st.tcnt[b][p] = st_ff.tcnt[b][p] + 1'b1;
                    end
                end
                // global flag and quiet-window count, updated once per global window
                if (gw_end) begin
                    nhist = {st_ff.hist[b][HIST_DEPTH-2:0], exceeded[b]};
                    nxt_st.hist[b] = nhist;
                    if (closed_loop_select_i) begin
                        nxt_st.gflag[b] = |nhist;
                        nxt_st.quiet[b] = '0;
                    end else if (exceeded[b]) begin
                        nxt_st.gflag[b] = 1'b1;
                        nxt_st.quiet[b] = '0;
                    end else if (st_ff.gflag[b]) begin
                        if (st_ff.quiet[b] >= quiet_last) begin
                            nxt_st.gflag[b] = 1'b0;
                            nxt_st.quiet[b] = '0;
                        end else begin
                            nxt_st.quiet[b] = st_ff.quiet[b] + 1'b1;
                        end
                    end
                end
                // latest zone reported by the module buffers of this branch
                if (status_valid_i[b]) begin
                    nxt_st.zone[b] = temp_above_mid_i[b] ? MAT_LVL_HIGH
                                   : temp_above_low_i[b] ? MAT_LVL_MID : MAT_LVL_LOW;
                end
                nxt_st.level[b] = pick_level(closed_loop_select_i, nxt_st.zone[b], nxt_st.gflag[b]);
                nxt_st.limit[b] = level_limit(nxt_st.level[b], low_throttle_level_i,
                                              mid_throttle_level_i, high_throttle_level_i);
                // stall holds to the window end even if the limit is raised meanwhile
                hit = 1'b0;
                for (int p = 0; p < NP; p++) begin
                    if (nxt_st.tcnt[b][p] >= nxt_st.limit[b]) begin
                        hit = 1'b1;
                    end
                end
                nxt_st.stall[b] = (st_ff.stall[b] && !tw_end) || hit;
                // grace, given only when the bank is open, covers the follow-on access and one page hit
                if (nxt_st.stall[b] && !st_ff.stall[b]) begin
                    nxt_st.grace[b] = page_open_i[b] ? GRACE_ACCESSES : 2'h0;
                end else if (!nxt_st.stall[b]) begin
                    nxt_st.grace[b] = 2'h0;
                end else if (cas_issue_i[b] && st_ff.grace[b] != 2'h0) begin
                    nxt_st.grace[b] = st_ff.grace[b] - 1'b1;
                end
                nxt_st.cas_ok[b] = !nxt_st.stall[b] || nxt_st.grace[b] != 2'h0;
            end
        end
    end

    // reset leaves flags and counters clear and the low level selected
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status outputs, all straight from state
    assign global_throttle_flag_o = st_ff.gflag;
    assign active_throttle_limit_o = st_ff.limit;
    assign throttle_level_o = st_ff.level;
    assign branch_stall_o = st_ff.stall;
    assign cas_allow_o = st_ff.cas_ok;

    ////////////////////////////////////////////////////////////////////////
    // electrical throttle: one limiter per rank, one enable per pair
    for (genvar g = 0; g < NB * NP * RANKS_PER_PAIR; g++) begin : g_faw
        localparam int B = g / (NP * RANKS_PER_PAIR);
        localparam int P = (g / RANKS_PER_PAIR) % NP;
        localparam int R = g % RANKS_PER_PAIR;
        mat_rank_faw #(
            .EW(EW)
        ) u_faw (
            .sys_clk_i(sys_clk_i),
            .reset_n_i(reset_n_i),
            .ce_i(ce_i),
            .en_i(per_pair_electrical_enable_i[B*NP+P]),
            .act_i(act_valid_i[B] && act_pair_i[B*PW +: PW] == PW'(P) && act_rank_i[B] == R[0]),
            .win_i(electrical_window_setting_i),
            .block_o(rank_act_block_o[g])
        );
    end

    // sync packet cadence per channel
    for (genvar c = 0; c < NCH; c++) begin : g_sync
        mat_sync_gen u_sync (
            .sys_clk_i(sys_clk_i),
            .reset_n_i(reset_n_i),
            .ce_i(ce_i),
            .frame_tick_i(frame_tick_i[c]),
            .sync_send_o(sync_send_o[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_gw_close(int b);
        ce_i && gw_end && exceeded[b];
    endsequence

    chk_tw_wrap: assert property (ce_i && tw_end |=> st_ff.tw_cnt == '0)
        else $error("thermal window did not wrap after its last cycle");
    chk_gw_short_len: assert property (ce_i && short_window_select_i && tw_end
        && st_ff.gw_cnt == GW_W'(GW_SHORT_TW - 1) |=> st_ff.gw_cnt == '0)
        else $error("short global window not four thermal windows");
    chk_flag_set: assert property (s_gw_close(0) and !closed_loop_select_i
        |=> global_throttle_flag_o[0] && st_ff.quiet[0] == '0)
        else $error("overrun did not set flag and restart quiet count");
    chk_flag_clear: assert property (ce_i && gw_end && !closed_loop_select_i && !exceeded[0]
        && st_ff.gflag[0] && st_ff.quiet[0] == quiet_last |=> !global_throttle_flag_o[0])
        else $error("flag not cleared after quiet windows");
    chk_flag_early: assert property (ce_i && gw_end && !closed_loop_select_i && st_ff.gflag[0]
        && st_ff.quiet[0] < quiet_last |=> global_throttle_flag_o[0])
        else $error("flag cleared before quiet count complete");
    chk_closed_hist: assert property (s_gw_close(1) and closed_loop_select_i
        |=> global_throttle_flag_o[1] && throttle_level_o[3:2] != MAT_LVL_LOW)
        else $error("closed loop overrun did not raise level");
    chk_open_no_high: assert property (ce_i && !closed_loop_select_i
        |=> throttle_level_o[1:0] != MAT_LVL_HIGH && throttle_level_o[3:2] != MAT_LVL_HIGH)
        else $error("open loop used high level");
    chk_hot_high: assert property (ce_i && closed_loop_select_i && status_valid_i[0]
        && temp_above_mid_i[0] |=> throttle_level_o[1:0] == MAT_LVL_HIGH
        && active_throttle_limit_o[LW-1:0] == $past(high_throttle_level_i))
        else $error("hot module did not select high level");
    chk_low_needs_clear: assert property (throttle_level_o[1:0] == MAT_LVL_LOW
        |-> !global_throttle_flag_o[0])
        else $error("low level selected with flag set");
    chk_stall_holds: assert property (branch_stall_o[0] && !(ce_i && tw_end)
        |=> branch_stall_o[0])
        else $error("branch stall dropped before window end");
    chk_grace_gate: assert property (branch_stall_o[0] && st_ff.grace[0] == 2'h0
        |-> !cas_allow_o[0])
        else $error("access allowed on stalled branch without grace");

endmodule : mat_throttle_top
`default_nettype wire

//--- memory_activate_throttler_test.sv
// self-checking bench for the activate throttler
`timescale 1ns/1ps
`default_nettype none
module memory_activate_throttler_test;
    logic clk = 0, rst_n = 0, cl = 0, sw = 0, pg = 0, s;
    logic [7:0] glim = 8'h01;
    logic [15:0] lo = 0, mid = 0, hi = 0, ee = 0;
    logic [1:0] av = 0, ar = 0, cas = 0, slow = 0, sv, tl, tm, flag, stall, allow, v;
    logic [5:0] ap = 0;
    logic [3:0] ft = 0, zone = 0, sync, lvl;
    logic [31:0] lim, blk;
    int mismatches = 0, compares = 0, n;
    int q[$];
    // electrical window in cycles, as set on the controller input
    localparam int WIN = 10;

    mat_throttle_top i_mat_throttle_top (.sys_clk_i(clk), .reset_n_i(rst_n), .ce_i(1'b1),
        .closed_loop_select_i(cl), .short_window_select_i(sw), .global_activate_limit_i(glim),
        .low_throttle_level_i(lo), .mid_throttle_level_i(mid), .high_throttle_level_i(hi),
        .per_pair_electrical_enable_i(ee), .electrical_window_setting_i(5'(WIN)), .act_valid_i(av),
        .act_pair_i(ap), .act_rank_i(ar), .page_open_i({1'b0, pg}), .cas_issue_i(cas),
        .status_valid_i(sv), .temp_above_low_i(tl), .temp_above_mid_i(tm), .frame_tick_i(ft),
        .global_throttle_flag_o(flag), .active_throttle_limit_o(lim), .throttle_level_o(lvl),
        .branch_stall_o(stall), .cas_allow_o(allow), .rank_act_block_o(blk), .sync_send_o(sync));
    mat_buffer_model i_mat_buffer_model (.sys_clk_i(clk), .sync_i(sync), .zone_i(zone), .slow_i(slow),
        .status_valid_o(sv), .temp_above_low_o(tl), .temp_above_mid_o(tm));

    ////////////////////////////////////////////////////////////
    // clock, 20 ns period
    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // bounded wait on stall (sel 0) or flag (sel 1) of branch 0, flag of branch 1 (sel 2); n counts cycles
    task automatic wait_on(int sel, logic v, int bound);
        n = 0;
        while ((sel == 2 ? flag[1] : sel ? flag[0] : stall[0]) !== v) begin
            @(negedge clk);
            n++;
            if (n > bound) begin
                chk("wait", v, ~v);
                close_out();
            end
        end
    endtask : wait_on

    // cnt activates on branch b; keep repeats the last pair and rank
    task automatic acts(int cnt, int b = 0, bit keep = 0);
        if (!keep) begin
            ap[3*b +: 3] = 3'($urandom);
            ar[b] = 1'($urandom);
        end
        av[b] = 1'b1;
        repeat (cnt) @(negedge clk);
        av[b] = 1'b0;
    endtask : acts

    // reference level selection: hot wins in closed loop, then warm; the flag is not modelled, so open loop gives low
    function automatic logic [1:0] exp_lvl(logic c, int z);
        if (c && z == 2) return 2'h2;
        return (c && z == 1) ? 2'h1 : 2'h0;
    endfunction : exp_lvl

    ////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(99));
        lo = 16'h0100 + 16'($urandom % 256);
        mid = lo + 16'h0100;
        hi = mid + 16'h0100;
        slow = 2'($urandom);
        ee = 16'($urandom);
        repeat (2) @(negedge clk);
        rst_n = 1;
        repeat (2) @(negedge clk);
        chk("flag", 0, flag);
        chk("level", 0, lvl);
        chk("limit", lo, lim[15:0]);
        $display("test reset done");
        // temperature zones in closed then open loop
        for (int m = 0; m < 6; m++) begin
            cl = m < 3;
            zone = {2{2'(m % 3)}};
            ft = 4'hf;
            repeat (41) @(negedge clk);
            chk("early sync", 0, sync);
            @(negedge clk);
            ft = 0;
            s = sync[0];
            @(negedge clk);
            chk("sync", 1, s | sync[0]);
            repeat (12) @(negedge clk);
            chk("level", {2{exp_lvl(cl, m % 3)}}, lvl);
            v = exp_lvl(cl, m % 3);
            chk("limit", v[1] ? hi : v[0] ? mid : lo, lim[15:0]);
            chk("limit 1", v[1] ? hi : v[0] ? mid : lo, lim[31:16]);
        end
        $display("test temperature done");
        // electrical: four activates on one rank; the block is registered, so it must
        // stand while the oldest activate is fewer than WIN-1 edges back
        for (int e = 0; e < 2; e++) begin
            q = {};
            for (int i = 0; i < 4; i++) begin
                q.push_back(i);
            end
            acts(4, 0, e);
            for (int k = 0; k < 8; k++) begin
                n = 0;
                foreach (q[i]) begin
                    n += (3 + k - q[i] < WIN - 1);
                end
                chk("rank block", ee[ap[2:0]] && n >= 4, blk[2 * ap[2:0] + ar[0]]);
                chk("other rank", 0, blk[2 * ap[2:0] + !ar[0]]);
                @(negedge clk);
            end
            // second round: same rank with its pair enable flipped
            ee = ~ee;
        end
        $display("test electrical done");
        // six activates surely put three in one thermal window
        lo = 16'h0003;
        pg = 1;
        acts(6);
        wait_on(0, 1, 1400);
        wait_on(0, 0, 1400);
        acts(3);
        @(negedge clk);
        chk("stall", 4'hb, {allow[1], stall[1], stall[0], allow[0]});
        cas[0] = 1;
        repeat (2) @(negedge clk);
        cas[0] = 0;
        @(negedge clk);
        chk("cas allow", 0, allow[0]);
        wait_on(0, 0, 1400);
        chk("window", 1344, 16'(n + 7));
        lo = 16'h0100;
        $display("test stall done");
        // global window, short mode: 40 activates overrun whatever the phase
        sw = 1;
        acts(40);
        wait_on(1, 1, 5400);
        @(negedge clk);
        chk("level", 4'h1, lvl);
        wait_on(1, 0, 11000);
        chk("quiet time", 10752, 16'(n + 1));
        acts(16);
        repeat (5400) @(negedge clk);
        chk("flag at limit", 0, flag);
        wait_on(1, 0, 10);
        acts(17);
        wait_on(1, 1, 5400);
        acts(17);
        wait_on(1, 0, 17000);
        chk("restart time", 16128, 16'(n + 17));
        $display("test global done");
        // closed loop, cool modules: branch 1 overruns now, branch 0 overran within its last 8 windows
        cl = 1;
        zone = 0;
        ft = 4'hf;
        repeat (42) @(negedge clk);
        ft = 0;
        repeat (12) @(negedge clk);
        acts(17, 1);
        wait_on(2, 1, 5400);
        @(negedge clk);
        chk("closed flag", 2'h3, flag);
        chk("closed level", 4'h5, lvl);
        $display("test closed done");
        close_out();
    end
endmodule : memory_activate_throttler_test
`default_nettype wire
